// ---- hdl/mscg_halt_detect.sv ----
// Clock-halt detector: watches edges of the sampled clock input.
// Assumes ext_clk_sample is already synchronous to clk.
module mscg_halt_detect #(
    parameter int unsigned TIMEOUT_CYC = mscg_pkg::HALT_TIMEOUT_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Watched level
    input wire logic ext_clk_sample,
    // Result
    output logic halted
);
    localparam int unsigned CW = $clog2(TIMEOUT_CYC + 1);

    logic prev_level;
    logic [CW-1:0] gap_count;
    logic next_prev_level;
    logic [CW-1:0] next_gap_count;
    logic next_halted;

    // ==========================================================================
    // Gap counter
    // ==========================================================================
    // Our own clk is the free-running reference; any edge restarts the count
    always_comb begin
        next_prev_level = ext_clk_sample;
        next_gap_count = gap_count;
        next_halted = halted;
        if (ext_clk_sample != prev_level) begin
            next_gap_count = '0;
            next_halted = 1'b0;
        end else if (gap_count >= CW'(TIMEOUT_CYC)) begin
            next_halted = 1'b1;
        end else begin
            next_gap_count = gap_count + CW'(1);
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prev_level <= 1'b0;
            gap_count <= '0;
            halted <= 1'b0;
        end else begin
            prev_level <= next_prev_level;
            gap_count <= next_gap_count;
            halted <= next_halted;
        end
    end

endmodule : mscg_halt_detect

// ---- hdl/mscg_pkg.sv ----
// Package for the mode-select and clock-generation control block.
// Assumes a single 25 MHz clock domain and synchronous active-low reset.
package mscg_pkg;

    // ==========================================================================
    // Timing
    // ==========================================================================
    localparam int unsigned CLK_PERIOD_NS = 40;
    // Longest gap between clock-input edges before a halt is declared
    localparam int unsigned HALT_TIMEOUT_NS = 2000;
    localparam int unsigned HALT_TIMEOUT_CYC = (HALT_TIMEOUT_NS / CLK_PERIOD_NS < 1) ? 1 :
        HALT_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam int unsigned PRESCALE_WIDTH = 13;
    localparam logic [12:0] PRESCALE_RESET = 13'h0000;

    // ==========================================================================
    // Encodings
    // ==========================================================================
    localparam logic [1:0] PLL_X1 = 2'h0;
    localparam logic [1:0] PLL_X2 = 2'h1;
    localparam logic [1:0] PLL_X4 = 2'h2;
    localparam logic [1:0] PLL_RSVD = 2'h3;

    localparam logic [1:0] BUS_W8 = 2'h0;
    localparam logic [1:0] BUS_W16 = 2'h1;
    localparam logic [1:0] BUS_W32 = 2'h2;
    localparam logic [1:0] BUS_WCFG = 2'h3;

    // Operating modes, one-hot
    typedef enum logic [7:0] {
        MSCG_MODE_MCU0 = 8'h01,
        MSCG_MODE_MCU1 = 8'h02,
        MSCG_MODE_MCU2 = 8'h04,
        MSCG_MODE_SINGLE = 8'h08,
        MSCG_MODE_ROMPROG = 8'h10,
        MSCG_MODE_BOOT = 8'h20,
        MSCG_MODE_USERPROG = 8'h40,
        MSCG_MODE_INVALID = 8'h80
    } mscg_mode_type;

    // Decoded configuration carried as one bundle
    typedef struct packed {
        logic rom_enable;
        logic ext_addr_enable;
        logic rom_program;
        logic [1:0] cs0_width;
        logic [1:0] pll_mult;
    } mscg_cfg_type;

    localparam mscg_cfg_type CFG_RESET = '{rom_enable: 1'b0, ext_addr_enable: 1'b0,
        rom_program: 1'b0, cs0_width: 2'h0, pll_mult: 2'h0};

endpackage : mscg_pkg

// ---- hdl/mscg_top.sv ----
// Mode-pin decode, PLL multiplier select, prescaler and timer-pin guard.
// Assumes strap pins and clock-input sample are synchronous to clk.
// Pins forced to high impedance are also driven low.
//
// What this block does
// - Mode 0: ROM off, chip-select-zero external, 8 bit small, 16 bit large.
// - Mode 1: ROM off, chip-select-zero external, 16 bit small, 32 bit large.
// - Mode 2: ROM on over 32 bits; external width from bus config.
// - Single-chip mode: all ports general I/O, no external address accesses.
// - Write-protect pin and all four mode pins high enter ROM programming.
// - Clock-mode pins 00, 01, 10 give x1, x2, x4; 11 reserved.
// - Clock-mode pins mean clock mode only in operating modes 0 to 3.
// - Flash variant: second mode pin sampled when leaving reset.
// - Prescaler gives peripheral clocks from half to 1/8192 of system clock.
// - Clock halt forces six timer pins to high impedance.
// - Standby also holds the six timer pins at high impedance.
// - Timer pins return to configured behaviour once standby is cancelled.
// - Halt outside standby leaves operation undefined, even after restart.
// - Sleep with standby-select set enters standby, halting clock and CPU.
module mscg_top #(
    parameter int unsigned HALT_CYC = mscg_pkg::HALT_TIMEOUT_CYC,
    parameter int unsigned PIN_COUNT = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,

    // Strap pins
    input wire logic op_mode_pin_0,
    input wire logic op_mode_pin_1,
    input wire logic clk_mode_pin_0,
    input wire logic clk_mode_pin_1,
    input wire logic flash_write_protect_pin,
    input wire logic large_package,
    input wire logic flash_variant,

    // Configuration from elsewhere
    input wire logic [1:0] bus_width_config,
    input wire logic standby_select,
    input wire logic sleep_exec,
    input wire logic standby_cancel,

    // Clock input level, sampled
    input wire logic ext_clock_in,

    // Timer pins as configured by pin-function control
    input wire logic [PIN_COUNT-1:0] timer_out,
    input wire logic [PIN_COUNT-1:0] timer_oe,

    // Decoded configuration
    output mscg_pkg::mscg_cfg_type cfg,
    output mscg_pkg::mscg_mode_type mode,
    output logic ports_general_io,

    // Power state and clocks
    output logic standby,
    output logic clk_halted,
    output logic state_undefined,
    output logic [mscg_pkg::PRESCALE_WIDTH-1:0] periph_clk,

    // Guarded timer pins
    output logic [PIN_COUNT-1:0] timer_pin_out,
    output logic [PIN_COUNT-1:0] timer_pin_oe
);

    // ==========================================================================
    // Decode helpers
    // ==========================================================================
    // Operating mode from the five strap pins
    function automatic mscg_pkg::mscg_mode_type mscg_decode(input logic wp,
        input logic [3:0] md);
        mscg_pkg::mscg_mode_type m;

        m = mscg_pkg::MSCG_MODE_INVALID;
        // Protect pin low selects the flash programming modes
        if (wp) begin
            if (md == 4'hf) begin
                m = mscg_pkg::MSCG_MODE_ROMPROG;
            end else begin
                case (md[1:0])
                    2'h0: m = mscg_pkg::MSCG_MODE_MCU0;
                    2'h1: m = mscg_pkg::MSCG_MODE_MCU1;
                    2'h2: m = mscg_pkg::MSCG_MODE_MCU2;
                    default: m = mscg_pkg::MSCG_MODE_SINGLE;
                endcase
            end
        end else begin
            case (md[1:0])
                2'h0: m = mscg_pkg::MSCG_MODE_BOOT;
                2'h2: m = mscg_pkg::MSCG_MODE_USERPROG;
                default: m = mscg_pkg::MSCG_MODE_INVALID;
            endcase
        end

        return m;
    endfunction : mscg_decode

    // Configuration bundle for one mode
    function automatic mscg_pkg::mscg_cfg_type mscg_config(input mscg_pkg::mscg_mode_type m,
        input logic big, input logic [1:0] cm);
        mscg_pkg::mscg_cfg_type c;

        c = mscg_pkg::CFG_RESET;
        c.pll_mult = cm;

        case (m)
            mscg_pkg::MSCG_MODE_MCU0: begin
                c.ext_addr_enable = 1'b1;
                c.cs0_width = big ? mscg_pkg::BUS_W16 : mscg_pkg::BUS_W8;
            end
            mscg_pkg::MSCG_MODE_MCU1: begin
                c.ext_addr_enable = 1'b1;
                c.cs0_width = big ? mscg_pkg::BUS_W32 : mscg_pkg::BUS_W16;
            end
            mscg_pkg::MSCG_MODE_MCU2, mscg_pkg::MSCG_MODE_BOOT, mscg_pkg::MSCG_MODE_USERPROG: begin
                c.rom_enable = 1'b1;
                c.ext_addr_enable = 1'b1;
                c.cs0_width = mscg_pkg::BUS_WCFG;
            end
            mscg_pkg::MSCG_MODE_SINGLE: begin
                c.rom_enable = 1'b1;
                c.ext_addr_enable = 1'b0;
            end
            mscg_pkg::MSCG_MODE_ROMPROG: begin
                c.rom_enable = 1'b1;
                c.rom_program = 1'b1;
                c.pll_mult = mscg_pkg::PLL_RSVD;
            end
            default: begin
                c.pll_mult = mscg_pkg::PLL_X1;
            end
        endcase

        // Clock-mode pins only count in modes 0 to 3; 11 there is reserved
        if (!(m inside {mscg_pkg::MSCG_MODE_MCU0,
            mscg_pkg::MSCG_MODE_MCU1,
            mscg_pkg::MSCG_MODE_MCU2,
            mscg_pkg::MSCG_MODE_SINGLE,
            mscg_pkg::MSCG_MODE_ROMPROG})) begin
            c.pll_mult = mscg_pkg::PLL_X1;
        end else if (m != mscg_pkg::MSCG_MODE_ROMPROG && cm == mscg_pkg::PLL_RSVD) begin
            c.pll_mult = mscg_pkg::PLL_X1;
        end

        return c;
    endfunction : mscg_config

    // ==========================================================================
    // Strap capture
    // ==========================================================================
    // Straps are latched on the first cycle after reset release. The board keeps
    // them fixed a flash part may move the second pin during reset and we
    // still take the level seen at release.
    logic captured;
    logic next_captured;

    mscg_pkg::mscg_mode_type next_mode;
    mscg_pkg::mscg_cfg_type next_cfg;
    logic next_ports_general_io;
    mscg_pkg::mscg_mode_type live_mode;

    // Live decode until captured, then hold; cs0_width still follows bus_width_config in mode 2, boot and user programming
    always_comb begin
        live_mode = mscg_decode(flash_write_protect_pin,
            {clk_mode_pin_1, clk_mode_pin_0, op_mode_pin_1, op_mode_pin_0});
        next_captured = 1'b1;
        next_mode = mode;
        next_cfg = cfg;
        next_ports_general_io = ports_general_io;
        if (!captured) begin
            next_mode = live_mode;
            next_cfg = mscg_config(live_mode, large_package, {clk_mode_pin_1, clk_mode_pin_0});
            next_ports_general_io = (live_mode == mscg_pkg::MSCG_MODE_SINGLE);
        end else if (!flash_variant) begin
            next_mode = mode; // Non-flash parts never re-sample
        end
        next_cfg.cs0_width = (next_mode inside {mscg_pkg::MSCG_MODE_MCU2, mscg_pkg::MSCG_MODE_BOOT,
            mscg_pkg::MSCG_MODE_USERPROG}) ? bus_width_config : next_cfg.cs0_width;
    end

    // Capture registers
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            captured <= 1'b0;
            mode <= mscg_pkg::MSCG_MODE_INVALID;
            cfg <= mscg_pkg::CFG_RESET;
            ports_general_io <= 1'b0;
        end else begin
            captured <= next_captured;
            mode <= next_mode;
            cfg <= next_cfg;
            ports_general_io <= next_ports_general_io;
        end
    end

    // ==========================================================================
    // Standby state
    // ==========================================================================
    // Entry is a sleep with standby-select set; cancel wins only once in standby
    logic next_standby;

    always_comb begin
        next_standby = standby;
        if (!standby && sleep_exec && standby_select) begin
            next_standby = 1'b1;
        end else if (standby && standby_cancel) begin
            next_standby = 1'b0;
        end
    end

    // Standby register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            standby <= 1'b0;
        end else begin
            standby <= next_standby;
        end
    end

    // ==========================================================================
    // Prescaler
    // ==========================================================================
    // Bit n toggles at system clock / 2^(n+1), giving /2 to /8192; held in standby
    logic [mscg_pkg::PRESCALE_WIDTH-1:0] next_periph_clk;

    // Frozen in standby, where the oscillator is stopped
    always_comb begin
        next_periph_clk = standby ? periph_clk : periph_clk + 13'h0001;
    end

    // Prescaler register
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            periph_clk <= mscg_pkg::PRESCALE_RESET;
        end else begin
            periph_clk <= next_periph_clk;
        end
    end

    // ==========================================================================
    // Halt detection and timer-pin guard
    // ==========================================================================
    logic halt_raw;
    // Held clear in standby, else a stale count flags a halt on wake-up
    logic halt_rst_b;

    always_comb begin
        halt_rst_b = rst_b && !standby;
    end

    mscg_halt_detect #(
        .TIMEOUT_CYC(HALT_CYC)
    ) u_halt (
        .clk(clk),
        .rst_b(halt_rst_b),
        .ext_clk_sample(ext_clock_in),
        .halted(halt_raw)
    );

    // In standby the clock input is held high, so the halt flag is masked there
    logic next_clk_halted;
    logic next_state_undefined;
    logic [PIN_COUNT-1:0] next_pin_out;
    logic [PIN_COUNT-1:0] next_pin_oe;

    // Pins follow their configuration unless guarded
    always_comb begin
        next_clk_halted = halt_raw && !standby;
        // Sticky: a halt outside standby is never healed, only reset clears it
        next_state_undefined = state_undefined || next_clk_halted;
        next_pin_out = timer_out;
        next_pin_oe = timer_oe;
        if (next_clk_halted || state_undefined) begin
            next_pin_oe = '0;
            next_pin_out = '0;
        end else if (next_standby) begin
            next_pin_oe = '0;
            next_pin_out = '0;
        end
    end

    // Guarded outputs, straight from flops
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            clk_halted <= 1'b0;
            state_undefined <= 1'b0;
            timer_pin_out <= '0;
            timer_pin_oe <= '0;
        end else begin
            clk_halted <= next_clk_halted;
            state_undefined <= next_state_undefined;
            timer_pin_out <= next_pin_out;
            timer_pin_oe <= next_pin_oe;
        end
    end

endmodule : mscg_top

// ---- test/mscg_board.sv ----
// Board model: strap pins and an external clock source.
// Assumes the bench supplies the strap code while reset is low.
module mscg_board (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Control from bench and device
    input wire logic [6:0] strap_code,
    input wire logic run,
    input wire logic standby,
    // Pins to the device
    output logic [6:0] straps = 7'h00,
    output logic ext_clock_in = 1'b0
);
    timeunit 1ns;
    timeprecision 1ns;
    // Straps follow the bench only in reset, then stay put while powered
    always @(negedge clk) begin
        if (!rst_b) begin
            straps <= strap_code;
        end
    end
    // A 150 ns period, unrelated to the system clock; clearing run models a dead oscillator
    always begin
        #75;
        if (standby) begin
            ext_clock_in <= 1'b1;
        end else if (run) begin
            ext_clock_in <= ~ext_clock_in;
        end
    end
endmodule : mscg_board

// ---- test/mscg_top_asserts.sv ----
// Checker for the mode-select and clock-generation block.
// Assumes it is bound to mscg_top and sees only that module's ports.
module mscg_top_asserts #(
    parameter int unsigned HALT_CYC = 4,
    parameter int unsigned PIN_COUNT = 6
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Inputs watched
    input wire logic [1:0] bus_width_config,
    input wire logic standby_select,
    input wire logic sleep_exec,
    input wire logic ext_clock_in,
    input wire logic [PIN_COUNT-1:0] timer_oe,
    // Outputs watched
    input wire mscg_pkg::mscg_cfg_type cfg,
    input wire mscg_pkg::mscg_mode_type mode,
    input wire logic ports_general_io,
    input wire logic standby,
    input wire logic clk_halted,
    input wire logic state_undefined,
    input wire logic [mscg_pkg::PRESCALE_WIDTH-1:0] periph_clk,
    input wire logic [PIN_COUNT-1:0] timer_pin_oe
);
    // ==========================================================================
    // Steady-level counter
    // ==========================================================================
    logic [7:0] cnt;
    logic [7:0] next_cnt;
    logic last_lvl;
    // Standby clears the count, since the input is parked high there on purpose
    always_comb begin
        next_cnt = cnt;
        if (!rst_b || standby || ext_clock_in != last_lvl) begin
            next_cnt = 8'h00;
        end else if (cnt != 8'hff) begin
            next_cnt = cnt + 8'h01;
        end
    end
    // Register the count and the last level seen
    always_ff @(posedge clk) begin
        cnt <= next_cnt;
        last_lvl <= ext_clock_in;
    end

    // ==========================================================================
    // Properties
    // ==========================================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    // Standby and the guarded timer pins
    property p_standby_entry; sleep_exec && standby_select && !standby |=> standby; endproperty
    a_standby_entry: assert property (p_standby_entry) else $error("standby not entered");
    property p_pins_hiz; standby || clk_halted || state_undefined |-> timer_pin_oe == {PIN_COUNT{1'b0}}; endproperty
    a_pins_hiz: assert property (p_pins_hiz) else $error("timer pins driven while guarded");
    property p_pins_follow; $past(rst_b) && $past(rst_b, 2) && !standby && !clk_halted && !state_undefined
        |-> timer_pin_oe == $past(timer_oe); endproperty
    a_pins_follow: assert property (p_pins_follow) else $error("timer pins not following");
    // Halt detection; the margin of three covers the detector's own latency
    property p_undef_sticky; $past(rst_b) && $past(state_undefined) |-> state_undefined; endproperty
    a_undef_sticky: assert property (p_undef_sticky) else $error("undefined flag dropped");
    property p_halt_flag; cnt >= 8'(HALT_CYC + 3) |-> clk_halted && state_undefined; endproperty
    a_halt_flag: assert property (p_halt_flag) else $error("halt not flagged");
    // Prescaler runs outside standby and holds inside it
    property p_presc; $past(rst_b) && !$past(standby) && !standby |-> periph_clk == $past(periph_clk) + 1'b1;
    endproperty
    a_presc: assert property (p_presc) else $error("prescaler not counting");
    property p_presc_hold; standby && $past(standby) |-> $stable(periph_clk); endproperty
    a_presc_hold: assert property (p_presc_hold) else $error("prescaler runs in standby");
    // Decoded mode and configuration
    property p_mode_held; $past(rst_b) && $past(rst_b, 2) |-> $stable(mode); endproperty
    a_mode_held: assert property (p_mode_held) else $error("mode changed after capture");
    property p_single; ports_general_io == (mode == mscg_pkg::MSCG_MODE_SINGLE)
        && !(ports_general_io && cfg.ext_addr_enable); endproperty
    a_single: assert property (p_single) else $error("single-chip decode wrong");
    property p_mcu2; $past(rst_b, 2) && mode == mscg_pkg::MSCG_MODE_MCU2
        |-> cfg.rom_enable && cfg.cs0_width == $past(bus_width_config); endproperty
    a_mcu2: assert property (p_mcu2) else $error("mode 2 width or ROM wrong");
    property p_romprog; mode == mscg_pkg::MSCG_MODE_ROMPROG |-> cfg.rom_program && cfg.pll_mult == 2'h3;
    endproperty
    a_romprog: assert property (p_romprog) else $error("ROM programming decode wrong");
endmodule : mscg_top_asserts

bind mscg_top mscg_top_asserts #(.HALT_CYC(HALT_CYC), .PIN_COUNT(PIN_COUNT)) i_mscg_top_asserts (
    .clk(clk), .rst_b(rst_b), .bus_width_config(bus_width_config), .standby_select(standby_select),
    .sleep_exec(sleep_exec), .ext_clock_in(ext_clock_in), .timer_oe(timer_oe), .cfg(cfg), .mode(mode),
    .ports_general_io(ports_general_io), .standby(standby), .clk_halted(clk_halted),
    .state_undefined(state_undefined), .periph_clk(periph_clk), .timer_pin_oe(timer_pin_oe));

// ---- test/mscg_top_tb.sv ----
// Self-checking bench for the mode-select and clock-generation block.
// Assumes the board model drives the straps and the clock input.
module mscg_top_tb;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct {int k; logic [12:0] e; logic [12:0] m;} mscg_note_type;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic run = 1'b1;
    logic [6:0] strap_code = 7'h00;
    logic [6:0] straps;
    logic ext_clock_in;
    logic [1:0] bus_width_config = 2'h0;
    logic standby_select = 1'b0;
    logic sleep_exec = 1'b0;
    logic standby_cancel = 1'b0;
    logic [5:0] timer_out = 6'h00;
    logic [5:0] timer_oe = 6'h00;
    mscg_pkg::mscg_cfg_type cfg;
    mscg_pkg::mscg_mode_type mode;
    logic ports_general_io, standby, clk_halted, state_undefined;
    logic [12:0] periph_clk;
    logic [5:0] timer_pin_out, timer_pin_oe;
    int bad_count = 0;
    int checks_done = 0;
    int k;
    logic [31:0] rng = 32'h0000_0004;
    logic [6:0] s;
    logic [13:0] ec;
    logic [12:0] seen;
    mscg_note_type cur;
    mscg_note_type notes[$];
    event look;
    string names[9] = '{"mode", "cfg", "gio", "standby", "halted", "undefined", "pin_oe", "pin_out", "periph"};

    // ==========================================================================
    // Clock, board and design
    // ==========================================================================
    always #20 clk = ~clk;
    mscg_board i_mscg_board (.clk(clk), .rst_b(rst_b), .strap_code(strap_code), .run(run),
        .standby(standby), .straps(straps), .ext_clock_in(ext_clock_in));
    mscg_top #(.HALT_CYC(4), .PIN_COUNT(6)) i_mscg_top (.clk(clk), .rst_b(rst_b),
        .op_mode_pin_0(straps[0]), .op_mode_pin_1(straps[1]), .clk_mode_pin_0(straps[2]),
        .clk_mode_pin_1(straps[3]), .flash_write_protect_pin(straps[4]), .large_package(straps[5]),
        .flash_variant(straps[6]), .bus_width_config(bus_width_config), .standby_select(standby_select),
        .sleep_exec(sleep_exec), .standby_cancel(standby_cancel), .ext_clock_in(ext_clock_in),
        .timer_out(timer_out), .timer_oe(timer_oe), .cfg(cfg), .mode(mode), .ports_general_io(ports_general_io),
        .standby(standby), .clk_halted(clk_halted), .state_undefined(state_undefined), .periph_clk(periph_clk),
        .timer_pin_out(timer_pin_out), .timer_pin_oe(timer_pin_oe));

    // ==========================================================================
    // Helpers
    // ==========================================================================
    function automatic logic [31:0] xs();
        rng = rng ^ (rng << 13);
        rng = rng ^ (rng >> 17);
        rng = rng ^ (rng << 5);
        return rng;
    endfunction : xs
    // Strap code bits: variant, package, protect, clock mode 1..0, mode 1..0
    function automatic logic [7:0] exp_mode(input logic [6:0] v);
        case ({v[4], v[1:0]})
            3'b100: return 8'h01;
            3'b101: return 8'h02;
            3'b110: return 8'h04;
            3'b111: return (v[3] & v[2]) ? 8'h10 : 8'h08;
            3'b000: return 8'h20;
            3'b010: return 8'h40;
            default: return 8'h80;
        endcase
    endfunction : exp_mode
    // Mask in the upper seven bits; fields the modes leave open are masked off
    function automatic logic [13:0] exp_cfg(input logic [6:0] v, input logic [1:0] w);
        logic [1:0] pll;
        pll = (v[3:2] == 2'h3) ? 2'h0 : v[3:2];
        case (exp_mode(v))
            8'h01: return {7'h7f, 3'b010, v[5] ? 2'h1 : 2'h0, pll};
            8'h02: return {7'h7f, 3'b010, v[5] ? 2'h2 : 2'h1, pll};
            8'h04: return {7'h7f, 3'b110, w, pll};
            8'h08: return {7'h73, 3'b100, 2'h0, pll};
            8'h10: return {7'h53, 3'b101, 2'h0, 2'h3};
            8'h20, 8'h40: return {7'h4f, 3'b100, w, 2'h0};
            default: return {7'h7f, 7'h00};
        endcase
    endfunction : exp_cfg
    task automatic cmp(input string n, input logic [12:0] e, input logic [12:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask : cmp
    // The pause lets the watcher take each note
    task automatic note(input int kd, input logic [12:0] e, input logic [12:0] m);
        notes.push_back('{kd, e, m});
        -> look;
        #1;
    endtask : note
    task automatic do_reset(input logic [6:0] v);
        rst_b = 1'b0;
        strap_code = v ^ {5'h00, v[6], 1'b0};
        repeat (8) @(negedge clk);
        strap_code = v;
        repeat (8) @(negedge clk);
        rst_b = 1'b1;
        repeat (2) @(negedge clk);
    endtask : do_reset
    task automatic end_of_test();
        $display("checks_done=%0d bad_count=%0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test

    // ==========================================================================
    // Watcher and main sequence
    // ==========================================================================
    // Take the oldest note whenever a result is due and compare it with the outputs
    always @(look) begin
        cur = notes.pop_front();
        case (cur.k)
            0: seen = {5'h00, mode};
            1: seen = {6'h00, cfg};
            2: seen = {12'h000, ports_general_io};
            3: seen = {12'h000, standby};
            4: seen = {12'h000, clk_halted};
            5: seen = {12'h000, state_undefined};
            6: seen = {7'h00, timer_pin_oe};
            8: seen = periph_clk;
            default: seen = {7'h00, timer_pin_out};
        endcase
        cmp(names[cur.k], cur.e & cur.m, seen & cur.m);
    end
    // Each protect, clock-mode and mode pin code once with random package and variant, then standby, then a dead oscillator
    initial begin
        for (int i = 0; i < 32; i++) begin
            rng = xs();
            s = {rng[9:8], i[4:0]};
            bus_width_config = rng[1:0] % 2'h3;
            timer_out = rng[15:10];
            timer_oe = rng[21:16];
            do_reset(s);
            ec = exp_cfg(s, bus_width_config);
            note(0, {5'h00, exp_mode(s)}, 13'h00ff);
            note(1, {6'h00, ec[6:0]}, {6'h00, ec[13:7]});
            note(2, {12'h000, exp_mode(s) == 8'h08}, 13'h0001);
            note(6, {7'h00, timer_oe}, 13'h003f);
            note(8, mscg_pkg::PRESCALE_RESET + 13'h0002, 13'h1fff);
            bus_width_config = (bus_width_config == 2'h2) ? 2'h0 : bus_width_config + 2'h1;
            repeat (2) @(negedge clk);
            ec = exp_cfg(s, bus_width_config);
            note(1, {6'h00, ec[6:0]}, {6'h00, ec[13:7]});
        end
        sleep_exec = 1'b1;
        @(negedge clk);
        note(3, 13'h0000, 13'h0001);
        standby_select = 1'b1;
        @(negedge clk);
        sleep_exec = 1'b0;
        note(3, 13'h0001, 13'h0001);
        note(6, 13'h0000, 13'h003f);
        repeat (12) @(negedge clk);
        note(4, 13'h0000, 13'h0001);
        standby_cancel = 1'b1;
        @(negedge clk);
        standby_cancel = 1'b0;
        note(3, 13'h0000, 13'h0001);
        note(6, {7'h00, timer_oe}, 13'h003f);
        note(7, {7'h00, timer_out}, 13'h003f);
        repeat (8) @(negedge clk);
        note(6, {7'h00, timer_oe}, 13'h003f);
        run = 1'b0;
        for (k = 0; k < 40 && clk_halted !== 1'b1; k++) @(negedge clk);
        if (k == 40) begin
            bad_count++;
            end_of_test();
        end
        note(4, 13'h0001, 13'h0001);
        note(5, 13'h0001, 13'h0001);
        note(6, 13'h0000, 13'h003f);
        run = 1'b1;
        repeat (12) @(negedge clk);
        note(4, 13'h0000, 13'h0001);
        note(5, 13'h0001, 13'h0001);
        do_reset(s);
        note(5, 13'h0000, 13'h0001);
        end_of_test();
    end
    // Bound the whole run so a hang still reaches the verdict
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test();
    end
endmodule : mscg_top_tb
